// ===== lpi_defs.svh
// Constants for the power-on initializer: offsets, fields, resets, timing
`ifndef LPI_DEFS_SVH
`define LPI_DEFS_SVH
// Register byte offsets
`define LPI_ADDR_CMD 8'h00
`define LPI_ADDR_DATA 8'h04
`define LPI_ADDR_STATUS 8'h08
// Status word fields
`define LPI_ST_BUSY_BIT 0
`define LPI_ST_AC_LSB 8
`define LPI_ST_CFG_LSB 16
`define LPI_ST_NIB_BIT 24
// Data word fields
`define LPI_DT_USER_BIT 8
`define LPI_DT_GLYPH_LSB 9
// Instruction field positions
`define LPI_FS_WIDTH_BIT 4
`define LPI_FS_LINES_BIT 3
`define LPI_FS_FONT_BIT 2
`define LPI_DC_DISP_BIT 2
`define LPI_DC_CUR_BIT 1
`define LPI_DC_BLINK_BIT 0
`define LPI_EM_INC_BIT 1
`define LPI_EM_SHIFT_BIT 0
`define LPI_SH_SC_BIT 3
`define LPI_SH_RL_BIT 2
// Reset and power-on default values
`define LPI_CFG_RESET 8'h00
`define LPI_PWR_WIDTH 1'h1
`define LPI_PWR_LINES 1'h0
`define LPI_PWR_FONT 1'h0
`define LPI_PWR_DISP 1'h0
`define LPI_PWR_CUR 1'h0
`define LPI_PWR_BLINK 1'h0
`define LPI_PWR_INC 1'h1
`define LPI_PWR_SHIFT 1'h0
`define LPI_BLANK_CHAR 8'h20
`define LPI_AC_LAST 7'h7F
// Bus responses
`define LPI_RESP_OKAY 2'h0
`define LPI_RESP_SLVERR 2'h2
// Timing
`define LPI_CLK_KHZ 40000
`define LPI_BUSY_TIME_MS 10
`define LPI_BUSY_CYCLES (`LPI_BUSY_TIME_MS * `LPI_CLK_KHZ)
`endif

// ===== lpi_pkg.sv
// Types shared by the power-on initializer
`default_nettype none
package lpi_pkg;
  // Sequencer states, one-hot
  typedef enum logic [6:0]
  {
    st_wait = 7'h01,
    st_busy = 7'h02,
    st_clear = 7'h04,
    st_func = 7'h08,
    st_disp = 7'h10,
    st_entry = 7'h20,
    st_idle = 7'h40
  } lpi_state_type;
  // Display configuration
  typedef struct packed
  {
    logic width;
    logic lines;
    logic font;
    logic disp_on;
    logic cursor_on;
    logic blink;
    logic inc;
    logic shift;
  } lpi_cfg_type;
endpackage
`default_nettype wire

// ===== lpi_display_data_ram.sv
// Display data memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module lpi_display_data_ram
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [6:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:127];

  // Array write
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ===== lpi_top.sv
// Power-on initializer of a character display controller
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lpi_defs.svh"
module lpi_top #(parameter int BUSY_CYCLES = `LPI_BUSY_CYCLES)
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Supply detector pin
  input wire logic supply_ok,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status
  output logic busy_indicator
);
  lpi_pkg::lpi_state_type state_q;
  lpi_pkg::lpi_cfg_type cfg_q;
  logic [1:0] sync_q;
  logic supply_s;
  logic init_q;
  logic [19:0] wait_cnt_q;
  logic [6:0] clr_cnt_q;
  logic [6:0] ac_q;
  logic nib_pend_q;
  logic [3:0] nib_hi_q;
  logic aw_have_q, w_have_q, ar_have_q;
  logic [7:0] aw_addr_q, ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire, wr_ok, byte_done, exec_cmd, data_wr, addr_ok;
  logic [7:0] wr_byte;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  logic [3:0] glyph_info;

  // Maps a character code to {user glyph, glyph index}
  function automatic logic [3:0] glyph_of(input logic [7:0] code);
    glyph_of = {code[7:4] == 4'h0, code[2:0]};
  endfunction

  // ****************************************
  // Supply synchronizer and sequencer
  // ****************************************

  // Two-flop synchronizer for the supply pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= 2'h0;
    end
    else
    begin
      sync_q <= {sync_q[0], supply_ok};
    end
  end
  assign supply_s = sync_q[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= lpi_pkg::st_wait;
    end
    else
    begin
      unique case (state_q)
        lpi_pkg::st_wait: if (supply_s) state_q <= lpi_pkg::st_busy;
        lpi_pkg::st_busy: if (wait_cnt_q == 20'(BUSY_CYCLES - 1)) state_q <= lpi_pkg::st_clear;
        lpi_pkg::st_clear:
        begin
          if (clr_cnt_q == `LPI_AC_LAST)
          begin
            state_q <= init_q ? lpi_pkg::st_func : lpi_pkg::st_idle;
          end
        end
        lpi_pkg::st_func: state_q <= lpi_pkg::st_disp;
        lpi_pkg::st_disp: state_q <= lpi_pkg::st_entry;
        lpi_pkg::st_entry: state_q <= lpi_pkg::st_idle;
        lpi_pkg::st_idle: if (exec_cmd && wr_byte == 8'h01) state_q <= lpi_pkg::st_clear;
      endcase
    end
  end

  // Marks the power-on pass until it finishes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_q <= 1'b1;
    end
    else if (state_q == lpi_pkg::st_entry)
    begin
      init_q <= 1'b0;
    end
  end

  // Busy period and clear sweep counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_cnt_q <= 20'h00000;
      clr_cnt_q <= 7'h00;
    end
    else
    begin
      wait_cnt_q <= (state_q == lpi_pkg::st_busy) ? wait_cnt_q + 20'h00001 : 20'h00000;
      clr_cnt_q <= (state_q == lpi_pkg::st_clear) ? clr_cnt_q + 7'h01 : 7'h00;
    end
  end

  assign busy_indicator = (state_q != lpi_pkg::st_idle);

  // ****************************************
  // Instruction assembly and execution
  // ****************************************

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign addr_ok = (aw_addr_q == `LPI_ADDR_CMD) || (aw_addr_q == `LPI_ADDR_DATA);
  // writes accepted only when not busy
  assign wr_ok = wr_fire && !busy_indicator && w_strb_q[0] && addr_ok;
  assign byte_done = wr_ok && (cfg_q.width || nib_pend_q);
  assign wr_byte = cfg_q.width ? w_data_q[7:0] : {nib_hi_q, w_data_q[7:4]};
  assign exec_cmd = byte_done && (aw_addr_q == `LPI_ADDR_CMD);
  assign data_wr = byte_done && (aw_addr_q == `LPI_ADDR_DATA);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nib_pend_q <= 1'b0;
      nib_hi_q <= 4'h0;
    end
    else if (wr_ok && !cfg_q.width)
    begin
      nib_pend_q <= !nib_pend_q;
      nib_hi_q <= w_data_q[7:4];
    end
  end

  // Configuration from power-on defaults and instructions
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= `LPI_CFG_RESET;
    end
    else if (init_q && state_q == lpi_pkg::st_func)
    begin
      cfg_q.width <= `LPI_PWR_WIDTH;
      cfg_q.lines <= `LPI_PWR_LINES;
      cfg_q.font <= `LPI_PWR_FONT;
    end
    else if (init_q && state_q == lpi_pkg::st_disp)
    begin
      cfg_q.disp_on <= `LPI_PWR_DISP;
      cfg_q.cursor_on <= `LPI_PWR_CUR;
      cfg_q.blink <= `LPI_PWR_BLINK;
    end
    else if (init_q && state_q == lpi_pkg::st_entry)
    begin
      cfg_q.inc <= `LPI_PWR_INC;
      cfg_q.shift <= `LPI_PWR_SHIFT;
    end
    else if (exec_cmd)
    begin
      casez (wr_byte)
        8'b001?????:
        begin
          cfg_q.width <= wr_byte[`LPI_FS_WIDTH_BIT];
          cfg_q.lines <= wr_byte[`LPI_FS_LINES_BIT];
          cfg_q.font <= wr_byte[`LPI_FS_FONT_BIT];
        end
        8'b00001???:
        begin
          cfg_q.disp_on <= wr_byte[`LPI_DC_DISP_BIT];
          cfg_q.cursor_on <= wr_byte[`LPI_DC_CUR_BIT];
          cfg_q.blink <= wr_byte[`LPI_DC_BLINK_BIT];
        end
        8'b000001??:
        begin
          cfg_q.inc <= wr_byte[`LPI_EM_INC_BIT];
          cfg_q.shift <= wr_byte[`LPI_EM_SHIFT_BIT];
        end
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Address counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ac_q <= 7'h00;
    end
    else if (state_q == lpi_pkg::st_clear && clr_cnt_q == `LPI_AC_LAST)
    begin
      ac_q <= 7'h00;
    end
    else if (data_wr)
    begin
      ac_q <= cfg_q.inc ? ac_q + 7'h01 : ac_q - 7'h01;
    end
    else if (exec_cmd)
    begin
      casez (wr_byte)
        8'b1???????: ac_q <= wr_byte[6:0];
        8'b0001????:
        begin
          if (!wr_byte[`LPI_SH_SC_BIT])
          begin
            ac_q <= wr_byte[`LPI_SH_RL_BIT] ? ac_q + 7'h01 : ac_q - 7'h01;
          end
        end
        8'b0000001?: ac_q <= 7'h00;
        default: ac_q <= ac_q;
      endcase
    end
  end

  assign mem_we = (state_q == lpi_pkg::st_clear) || data_wr;
  assign mem_waddr = (state_q == lpi_pkg::st_clear) ? clr_cnt_q : ac_q;
  assign mem_wdata = (state_q == lpi_pkg::st_clear) ? `LPI_BLANK_CHAR : wr_byte;

  // Display data memory
  lpi_display_data_ram u_ram
  (
    .clk(clk),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(ac_q),
    .rdata(mem_rdata)
  );

  // ****************************************
  // AXI4-Lite slave
  // ****************************************

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !ar_have_q && !s_axi_rvalid;

  // Write address, data and response
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPI_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok ? `LPI_RESP_OKAY : `LPI_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data selection
  assign glyph_info = glyph_of(mem_rdata);
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_resp = `LPI_RESP_OKAY;
    unique case (ar_addr_q)
      `LPI_ADDR_STATUS:
      begin
        rd_word[`LPI_ST_BUSY_BIT] = busy_indicator;
        rd_word[`LPI_ST_AC_LSB +: 7] = ac_q;
        rd_word[`LPI_ST_CFG_LSB +: 8] = cfg_q;
        rd_word[`LPI_ST_NIB_BIT] = nib_pend_q;
      end
      `LPI_ADDR_DATA:
      begin
        rd_word[7:0] = mem_rdata;
        rd_word[`LPI_DT_USER_BIT] = glyph_info[3];
        rd_word[`LPI_DT_GLYPH_LSB +: 3] = glyph_info[2:0];
      end
      `LPI_ADDR_CMD: rd_word = 32'h00000000;
      default: rd_resp = `LPI_RESP_SLVERR;
    endcase
  end

  // Read address and response
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ar_have_q <= 1'b0;
      ar_addr_q <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LPI_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      ar_have_q <= 1'b1;
      ar_addr_q <= s_axi_araddr;
    end
    else if (ar_have_q)
    begin
      ar_have_q <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_self_start: assert property ((state_q == lpi_pkg::st_wait) && supply_s |=> state_q == lpi_pkg::st_busy) else $error("no self start");
  a_busy_held: assert property ((state_q != lpi_pkg::st_idle) |-> busy_indicator) else $error("busy dropped early");
  a_busy_length: assert property ($fell(state_q == lpi_pkg::st_busy) |-> $past(wait_cnt_q) == 20'(BUSY_CYCLES - 1)) else $error("busy period wrong");
  a_init_order: assert property ((state_q == lpi_pkg::st_func) |=> (state_q == lpi_pkg::st_disp) ##1 (state_q == lpi_pkg::st_entry) ##1 (state_q == lpi_pkg::st_idle && !busy_indicator)) else $error("init order wrong");
  a_entry_default: assert property ((init_q && state_q == lpi_pkg::st_entry) |=> cfg_q.inc && !cfg_q.shift) else $error("entry default wrong");
  a_func_default: assert property ((init_q && state_q == lpi_pkg::st_func) |=> cfg_q.width && !cfg_q.font) else $error("function default wrong");
  a_busy_refuse: assert property ((wr_fire && busy_indicator && !init_q &&
    clr_cnt_q != `LPI_AC_LAST) |=> $stable(cfg_q) && $stable(ac_q))
    else $error("write taken while busy");
  a_clear_home: assert property ((state_q == lpi_pkg::st_clear && clr_cnt_q == `LPI_AC_LAST) |=> ac_q == 7'h00) else $error("clear not homed");
  a_nibble_pair: assert property ((wr_ok && !cfg_q.width && !nib_pend_q) |-> !byte_done ##1 nib_pend_q) else $error("nibble pairing wrong");
  a_func_fields: assert property ((exec_cmd && wr_byte[7:5] == 3'h1) |=> cfg_q.width == $past(wr_byte[4]) && cfg_q.lines == $past(wr_byte[3])) else $error("function fields wrong");
  a_glyph_alias: assert property ((ar_have_q && ar_addr_q == `LPI_ADDR_DATA && mem_rdata[7:4] == 4'h0) |=> s_axi_rdata[`LPI_DT_USER_BIT] && s_axi_rdata[`LPI_DT_GLYPH_LSB +: 3] == $past(mem_rdata[2:0])) else $error("glyph alias wrong");

  c_init_done: cover property ((state_q == lpi_pkg::st_entry) ##1 (state_q == lpi_pkg::st_idle));
  c_clear_cmd: cover property (exec_cmd && wr_byte == 8'h01);
  c_nibble_byte: cover property (byte_done && !cfg_q.width);
endmodule
`default_nettype wire

// ===== lpi_host_model.sv
// Host processor model driving the register bus of the initializer
`timescale 1ns/1ps
`default_nettype none
`include "lpi_defs.svh"
module lpi_host_model
(
  // Clock
  input wire logic clk,
  // Write channels
  output var logic [7:0] awaddr,
  output var logic awvalid,
  input wire logic awready,
  output var logic [31:0] wdata,
  output var logic [3:0] wstrb,
  output var logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output var logic bready,
  // Read channels
  output var logic [7:0] araddr,
  output var logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output var logic rready,
  // Bound exceeded on a wait
  output var logic timed_out
);
  // ************
  // Bus idle state
  // ************
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, timed_out} = '0;
  end

  // One write; lag cycles before the response is accepted
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input int lag,
                           output logic [1:0] r);
    int n;
    bit aw_done;
    bit w_done;
    n = 0;
    aw_done = 0;
    w_done = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    while (!(aw_done && w_done) && n < 100)
    begin
      @(posedge clk);
      n++;
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    repeat (lag) @(posedge clk);
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (bvalid !== 1'b1 && n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200)
      timed_out <= 1'b1;
  endtask

  // One read; lag cycles before the data is accepted
  task automatic axi_read(input logic [7:0] a, input int lag, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    araddr <= ~a;
    repeat (lag) @(posedge clk);
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200)
      timed_out <= 1'b1;
  endtask

  task automatic wait_ready();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    d = 32'h1;
    while (d[`LPI_ST_BUSY_BIT] !== 1'b0 && n < 400)
    begin
      axi_read(`LPI_ADDR_STATUS, 0, d, r);
      n++;
    end
    if (n >= 400)
      timed_out <= 1'b1;
  endtask

  // Byte sent as two nibbles, upper one first
  task automatic send_nibbles(input logic [7:0] a, input logic [7:0] b);
    logic [1:0] r;
    axi_write(a, {24'h0, b[7:4], 4'h0}, 0, r);
    axi_write(a, {24'h0, b[3:0], 4'h0}, 2, r);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the power-on initializer
`timescale 1ns/1ps
`default_nettype none
`include "lpi_defs.svh"
module testbench;
  localparam int BUSY_C = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy_indicator, timed_out;
  int err_total = 0;
  int cmp_count = 0;
  int busy_len = 0;
  logic [7:0] codes [4] = '{8'h03, 8'h0B, 8'h0F, 8'h10};

  lpi_top #(.BUSY_CYCLES(BUSY_C)) uut (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .busy_indicator(busy_indicator));

  lpi_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timed_out(timed_out));

  // ************
  // Clock, busy length, hang guard
  // ************
  always #12.5 clk = ~clk;

  // Busy cycles counted once the supply is good
  always @(posedge clk)
  begin
    if (supply_ok && busy_indicator === 1'b1)
      busy_len <= busy_len + 1;
    else if (!supply_ok)
      busy_len <= 0;
    if (timed_out === 1'b1)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.axi_write(a, d, 1, rs);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    host.axi_read(a, 1, rd, rs);
  endtask

  // ************
  // Scenarios
  // ************
  task automatic t_power_on();
    int n;
    n = 0;
    check(busy_indicator, 1'b1, "busy before supply");
    repeat (5) @(posedge clk);
    supply_ok <= 1'b1;
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_BUSY_BIT], 1'b1, "status busy at start");
    while (busy_indicator !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    check(n < 2000, 1'b1, "init finished");
    check(busy_len >= BUSY_C + 130 && busy_len <= BUSY_C + 140, 1'b1, "busy length");
  endtask

  task automatic t_defaults();
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_BUSY_BIT], 1'b0, "ready after init");
    check(rd[`LPI_ST_CFG_LSB +: 8], {`LPI_PWR_WIDTH, `LPI_PWR_LINES, `LPI_PWR_FONT,
      `LPI_PWR_DISP, `LPI_PWR_CUR, `LPI_PWR_BLINK, 2'b10}, "default cfg");
    check(rd[`LPI_ST_AC_LSB +: 7], 7'h00, "home after init");
    rd_reg(`LPI_ADDR_DATA);
    check(rd[7:0], `LPI_BLANK_CHAR, "blank after init");
  endtask

  task automatic t_chars();
    wr(`LPI_ADDR_DATA, 32'h41);
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_AC_LSB +: 7], 7'h01, "increment");
    wr(`LPI_ADDR_CMD, 32'h80);
    rd_reg(`LPI_ADDR_DATA);
    check(rd[8:0], 9'h041, "char readback");
  endtask

  task automatic t_glyph();
    for (int i = 0; i < 4; i++)
    begin
      wr(`LPI_ADDR_CMD, 32'h90 + i);
      wr(`LPI_ADDR_DATA, {24'h0, codes[i]});
      wr(`LPI_ADDR_CMD, 32'h90 + i);
      rd_reg(`LPI_ADDR_DATA);
      check(rd[11:8], {codes[i][2:0], codes[i] < 8'h10}, "glyph map");
    end
  endtask

  task automatic t_clear();
    wr(`LPI_ADDR_CMD, 32'h01);
    wr(`LPI_ADDR_DATA, 32'h55);
    check(rs, `LPI_RESP_OKAY, "write while busy");
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_BUSY_BIT], 1'b1, "busy in clear");
    check(rd[`LPI_ST_AC_LSB +: 7], 7'h13, "busy write dropped");
    host.wait_ready();
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_AC_LSB +: 7], 7'h00, "clear homes");
    rd_reg(`LPI_ADDR_DATA);
    check(rd[7:0], `LPI_BLANK_CHAR, "cell 0 blank");
    wr(`LPI_ADDR_CMD, 32'h91);
    rd_reg(`LPI_ADDR_DATA);
    check(rd[7:0], `LPI_BLANK_CHAR, "cell 0x11 blank");
  endtask

  task automatic t_nibble();
    wr(`LPI_ADDR_CMD, 32'h28);
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_CFG_LSB + 5 +: 3], 3'b010, "four-bit two lines");
    host.send_nibbles(`LPI_ADDR_CMD, 8'h85);
    host.axi_write(`LPI_ADDR_DATA, 32'h40, 3, rs);
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_NIB_BIT], 1'b1, "nibble pending");
    host.axi_write(`LPI_ADDR_DATA, 32'h20, 0, rs);
    rd_reg(`LPI_ADDR_STATUS);
    check({rd[`LPI_ST_NIB_BIT], rd[`LPI_ST_AC_LSB +: 7]}, 8'h06, "pair done");
    host.send_nibbles(`LPI_ADDR_CMD, 8'h85);
    host.axi_read(`LPI_ADDR_DATA, 4, rd, rs);
    check(rd[7:0], 8'h42, "upper nibble first");
    host.send_nibbles(`LPI_ADDR_CMD, 8'h34);
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_CFG_LSB + 5 +: 3], 3'b101, "eight-bit one line font");
  endtask

  task automatic t_errors();
    rd_reg(8'h0C);
    check(rs, `LPI_RESP_SLVERR, "unmapped read resp");
    check(rd, 32'h0, "unmapped read data");
    wr(`LPI_ADDR_STATUS, 32'h0);
    check(rs, `LPI_RESP_SLVERR, "status write");
    wr(`LPI_ADDR_CMD, 32'h0C);
    check(rs, `LPI_RESP_OKAY, "display on");
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_CFG_LSB + 2 +: 3], 3'b100, "display control");
  endtask

  task automatic t_cursor();
    wr(`LPI_ADDR_CMD, 32'h85);
    wr(`LPI_ADDR_CMD, 32'h14);
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_AC_LSB +: 7], 7'h06, "cursor right");
    wr(`LPI_ADDR_CMD, 32'h10);
    wr(`LPI_ADDR_CMD, 32'h04);
    wr(`LPI_ADDR_DATA, 32'h33);
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_AC_LSB +: 7], 7'h04, "left then decrement");
    check(rd[`LPI_ST_CFG_LSB + 1], 1'b0, "decrement mode");
    wr(`LPI_ADDR_CMD, 32'h02);
    rd_reg(`LPI_ADDR_STATUS);
    check(rd[`LPI_ST_AC_LSB +: 7], 7'h00, "cursor home");
    wr(`LPI_ADDR_CMD, 32'h85);
    rd_reg(`LPI_ADDR_DATA);
    check(rd[7:0], 8'h33, "decrement write cell");
  endtask

  // Reset in mid-run repeats the power-on pass
  task automatic t_restart();
    rst_n <= 1'b0;
    supply_ok <= 1'b0;
    repeat (3) @(posedge clk);
    check(busy_indicator, 1'b1, "busy in second reset");
    rst_n <= 1'b1;
    t_power_on();
    t_defaults();
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    check(busy_indicator, 1'b1, "busy in reset");
    rst_n <= 1'b1;
    t_power_on();
    t_defaults();
    t_chars();
    t_glyph();
    t_clear();
    t_nibble();
    t_errors();
    t_cursor();
    t_restart();
    report_and_stop();
  end
endmodule
`default_nettype wire
